// ---- verilog/pwr_pkg.sv ----
package pwr_pkg;
  localparam logic [11:0] ADDR_PERIOD  = 12'h000;
  localparam logic [11:0] ADDR_DUTY    = 12'h004;
  localparam logic [11:0] ADDR_CTRL    = 12'h008;
  localparam logic [11:0] ADDR_STATUS  = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_EN  = 12'h010;
  localparam logic [11:0] ADDR_COUNTER = 12'h014;
  localparam logic [7:0]  PERIOD_RST   = 8'hFF;
  localparam logic [9:0]  DUTY_RST     = 10'h000;
  // ctrl fields
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_PRE_LSB     = 2;
  // status / mask fields
  localparam int ST_SHUTDOWN_BIT  = 0;
  localparam int ST_PERIOD_BIT    = 1;
  // prescale codes
  localparam logic [1:0] PRE_DIV1  = 2'h0;
  localparam logic [1:0] PRE_DIV4  = 2'h1;
  localparam logic [3:0] PRE_CNT4  = 4'h3;
  localparam logic [3:0] PRE_CNT16 = 4'hF;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
endpackage

// ---- verilog/pwr_pwm.sv ----
// The register offsets and the APB register port were left to the implementer.
module pwr_pwm
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shutdown_in,
  output logic             pwm_out,
  output logic             shutdown_event_status,
  output logic             irq
);

  // software-visible registers
  logic [7:0]  pwm_period_register;
  logic [9:0]  duty_reg;
  logic        enable_reg;
  logic        auto_restart_enable;
  logic [1:0]  prescale_reg;
  logic [1:0]  irq_en_reg;
  logic        period_flag_reg;
  logic [1:0]  status_bits;

  // timebase
  logic [7:0]  period_counter;
  logic [1:0]  phase_reg;
  logic [3:0]  pre_reg;
  logic        instr_tick;
  logic        count_tick;
  logic        period_wrap;
  logic [9:0]  fine_pos;
  logic        pulse_ok;

  // shutdown synchroniser
  logic        sd_meta_reg;
  logic        sd_sync_reg;

  // bus decode
  logic        setup;
  logic        wr;
  logic        addr_ok;
  logic        wr_period;
  logic        wr_duty;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_irq_en;
  logic        sd_clr_wr;
  logic        pd_clr_wr;
  logic [31:0] rd_next;

  // one decode for every strobe, so writes, reads and errors agree
  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [11:0] offset);
    reg_hit = (a == offset);
  endfunction

  // access-phase write; pready is always high there, no wait state
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign addr_ok = reg_hit(paddr, pwr_pkg::ADDR_PERIOD)
                || reg_hit(paddr, pwr_pkg::ADDR_DUTY)
                || reg_hit(paddr, pwr_pkg::ADDR_CTRL)
                || reg_hit(paddr, pwr_pkg::ADDR_STATUS)
                || reg_hit(paddr, pwr_pkg::ADDR_IRQ_EN)
                || reg_hit(paddr, pwr_pkg::ADDR_COUNTER);

  // per-register write strobes
  assign wr_period = wr && reg_hit(paddr, pwr_pkg::ADDR_PERIOD);
  assign wr_duty   = wr && reg_hit(paddr, pwr_pkg::ADDR_DUTY);
  assign wr_ctrl   = wr && reg_hit(paddr, pwr_pkg::ADDR_CTRL);
  assign wr_status = wr && reg_hit(paddr, pwr_pkg::ADDR_STATUS);
  assign wr_irq_en = wr && reg_hit(paddr, pwr_pkg::ADDR_IRQ_EN);

  // sticky bits in register order
  assign status_bits = {period_flag_reg, shutdown_event_status};

  // shutdown pin is asynchronous, two flops before use
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sd_meta_reg <= 1'b0;
      sd_sync_reg <= 1'b0;
    end
    else
    begin
      sd_meta_reg <= shutdown_in;
      sd_sync_reg <= sd_meta_reg;
    end
  end

  // period register, reset to the longest period
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pwm_period_register <= pwr_pkg::PERIOD_RST;
    else if (wr_period)
      pwm_period_register <= pwdata[7:0];
  end

  // duty register, ten bits for the full resolution
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      duty_reg <= pwr_pkg::DUTY_RST;
    else if (wr_duty)
      duty_reg <= pwdata[9:0];
  end

  // timebase run bit
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      enable_reg <= 1'b0;
    else if (wr_ctrl)
      enable_reg <= pwdata[pwr_pkg::CTRL_ENABLE_BIT];
  end

  // restart arm, applies from the next clock on
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      auto_restart_enable <= 1'b0;
    else if (wr_ctrl)
      auto_restart_enable <= pwdata[pwr_pkg::CTRL_RESTART_BIT];
  end

  // prescale select; code 3 acts as divide by 16
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prescale_reg <= pwr_pkg::PRE_DIV1;
    else if (wr_ctrl)
      prescale_reg <= pwdata[pwr_pkg::CTRL_PRE_LSB +: 2];
  end

  // interrupt mask, same layout as status
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_en_reg <= 2'b00;
    else if (wr_irq_en)
      irq_en_reg <= pwdata[1:0];
  end

  // instruction clock enable: one pulse per four system clocks
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_reg <= 2'b00;
    else if (enable_reg)
      phase_reg <= phase_reg + 2'b01;
    else
      phase_reg <= 2'b00;
  end
  assign instr_tick = enable_reg && (phase_reg == pwr_pkg::INSTR_DIV_LAST);

  // prescaler, cleared by a control write and while the timebase is off
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pre_reg <= 4'h0;
    else if (!enable_reg || wr_ctrl)
      pre_reg <= 4'h0;
    else if (instr_tick)
    begin
      if (count_tick)
        pre_reg <= 4'h0;
      else
        pre_reg <= pre_reg + 4'h1;
    end
  end
  always_comb
  begin
    unique case (prescale_reg)
      pwr_pkg::PRE_DIV1: count_tick = instr_tick;
      pwr_pkg::PRE_DIV4:
        count_tick = instr_tick && (pre_reg[1:0] == pwr_pkg::PRE_CNT4[1:0]);
      default:
        count_tick = instr_tick && (pre_reg == pwr_pkg::PRE_CNT16);
    endcase
  end

  // fine position: counter plus two sub-step bits gives 4*(period+1) steps
  assign fine_pos = {period_counter, pre_phase_bits(prescale_reg, pre_reg,
                                                    phase_reg)};
  function automatic logic [1:0] pre_phase_bits(input logic [1:0] ps,
                                                input logic [3:0] pc,
                                                input logic [1:0] ph);
    unique case (ps)
      pwr_pkg::PRE_DIV1: pre_phase_bits = ph;
      pwr_pkg::PRE_DIV4: pre_phase_bits = pc[1:0];
      default:           pre_phase_bits = pc[3:2];
    endcase
  endfunction

  // period counter: zero up to period, then wrap
  assign period_wrap = count_tick && (period_counter == pwm_period_register);
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      period_counter <= 8'h00;
    else if (!enable_reg)
      period_counter <= 8'h00;
    else if (period_wrap)
      period_counter <= 8'h00;
    else if (count_tick)
      period_counter <= period_counter + 8'h01;
  end

  // width beyond the period would never end; pin is frozen instead
  assign pulse_ok = duty_reg <= {pwm_period_register, 2'b11};

  // shutdown status, set wins over software clear
  assign sd_clr_wr = wr_status && pwdata[pwr_pkg::ST_SHUTDOWN_BIT];
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      shutdown_event_status <= 1'b0;
    else if (sd_sync_reg)
      shutdown_event_status <= 1'b1;
    else if (auto_restart_enable)
      shutdown_event_status <= 1'b0;
    else if (sd_clr_wr)
      shutdown_event_status <= 1'b0;
  end

  // period-end event flag
  assign pd_clr_wr = wr_status && pwdata[pwr_pkg::ST_PERIOD_BIT];
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      period_flag_reg <= 1'b0;
    else if (period_wrap)
      period_flag_reg <= 1'b1;
    else if (pd_clr_wr)
      period_flag_reg <= 1'b0;
  end

  // pwm pin: off in shutdown, held when width is out of range
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pwm_out <= 1'b0;
    else if (sd_sync_reg || shutdown_event_status || !enable_reg)
      pwm_out <= 1'b0;
    else if (!pulse_ok)
      pwm_out <= pwm_out;
    else
      pwm_out <= fine_pos < duty_reg;
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(status_bits & irq_en_reg);
  end

  // read mux
  always_comb
  begin
    rd_next = 32'h0000_0000;
    unique case (paddr)
      pwr_pkg::ADDR_PERIOD:  rd_next[7:0] = pwm_period_register;
      pwr_pkg::ADDR_DUTY:    rd_next[9:0] = duty_reg;
      pwr_pkg::ADDR_CTRL:    rd_next[3:0] = {prescale_reg,
                                             auto_restart_enable, enable_reg};
      pwr_pkg::ADDR_STATUS:  rd_next[1:0] = status_bits;
      pwr_pkg::ADDR_IRQ_EN:  rd_next[1:0] = irq_en_reg;
      pwr_pkg::ADDR_COUNTER: rd_next[7:0] = period_counter;
      default:               rd_next = 32'h0000_0000;
    endcase
  end

  // pready answers every setup cycle: zero wait states
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // unmapped address refused in the same cycle as pready
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pslverr <= 1'b0;
    else
      pslverr <= setup && !addr_ok;
  end

  // read data taken at setup, so it stands in the access cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_next;
  end

endmodule

// ---- verif/pwr_pwm_monitor.sv ----
module pwr_pwm_monitor
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        shutdown_in,
  input wire logic        pwm_out,
  input wire logic        shutdown_event_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // apb answer: zero wait, one cycle, only in access
  a_ready_zero_wait:
    assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single:
    assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_access:
    assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_reads_zero:
    assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  // two sync flops plus the flag register give three cycles
  a_shut_sets:
    assert property (shutdown_in [*4] |-> shutdown_event_status)
    else $error("flag not set by condition");
  a_rise_cause:
    assert property ($rose(shutdown_event_status)
      |-> $past(shutdown_in, 2) || $past(shutdown_in, 3))
    else $error("flag set without condition");
  a_fall_cause:
    assert property ($fell(shutdown_event_status)
      |-> !$past(shutdown_in, 2) || !$past(shutdown_in, 3))
    else $error("flag cleared under condition");
  a_pwm_off:
    assert property (shutdown_event_status [*2] |-> !pwm_out)
    else $error("pwm active during shutdown");
  c_shut_rise: cover property ($rose(shutdown_event_status));
  c_shut_fall: cover property ($fell(shutdown_event_status));
  c_refused: cover property (pslverr);
endmodule

bind pwr_pwm pwr_pwm_monitor mon
(
  .ref_clk, .reset_n, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .shutdown_in, .pwm_out, .shutdown_event_status
);

// ---- verif/pwr_stage.sv ----
module pwr_stage
(
  input  wire logic ref_clk,
  input  wire logic pwm_out,
  input  wire logic trip,
  output logic      fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // overcurrent sense reports a fault one cycle after the trip command
  always_ff @(posedge ref_clk)
    fault <= trip;
endmodule

// ---- verif/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        reset_n, psel, penable, pwrite, pready, pslverr, e;
  logic        pwm_out, shutdown_in, shutdown_event_status, irq;
  logic        trip, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  p;
  logic [9:0]  d;
  int          n_errors = 0, compares = 0, cyc = 0, t0, t1;
  // clock, and a cycle count that cuts a hang short
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  pwr_pwm DUT
  (
    .ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .shutdown_in, .pwm_out,
    .shutdown_event_status, .irq
  );
  pwr_stage stage (.ref_clk, .pwm_out, .trip, .fault(shutdown_in));
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dat);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic watch();
    seen = 1'b0;
    repeat (40)
    begin
      @(posedge ref_clk);
      seen |= pwm_out;
    end
  endtask
  function automatic int period_of(input int pr, input int pv);
    return 4 * (pv + 1) * (pr == 0 ? 1 : pr == 1 ? 4 : 16);
  endfunction
  initial
  begin
    {psel, penable, pwrite, trip} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    reset_n = 1'b0;
    void'($urandom(6));
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, pwr_pkg::ADDR_PERIOD, 32'h0000_0000);
    chk(r, 32'h0000_00FF);
    apb(1'b0, 12'h03C, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk(e, 32'h0000_0001);
    // full ten-bit case first, then random periods per prescale code
    for (int i = 0; i < 4; i++)
    begin
      p = (i == 0) ? 8'hFF : 8'(1 + $urandom % 6);
      d = (i == 0) ? 10'h3FF : 10'(1 + $urandom % (4 * p + 3));
      apb(1'b1, pwr_pkg::ADDR_PERIOD, {24'h00_0000, p});
      apb(1'b1, pwr_pkg::ADDR_DUTY, {22'h00_0000, d});
      apb(1'b1, pwr_pkg::ADDR_CTRL, {28'h000_0000, i[1:0], 2'h1});
      repeat (2) @(posedge pwm_out);
      t0 = cyc;
      @(negedge pwm_out);
      t1 = cyc;
      @(posedge pwm_out);
      chk(cyc - t0, period_of(i, p));
      if (i == 0)
        chk(t1 - t0, d);
    end
    // period ends have set the sticky period bit, no shutdown yet
    apb(1'b0, pwr_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(r, 32'h0000_0002);
    // oversized width written while low: pin must stay low
    apb(1'b1, pwr_pkg::ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, pwr_pkg::ADDR_PERIOD, 32'h0000_0003);
    apb(1'b1, pwr_pkg::ADDR_DUTY, 32'h0000_0005);
    @(negedge pwm_out);
    apb(1'b1, pwr_pkg::ADDR_DUTY, 32'h0000_0011);
    repeat (20) @(posedge ref_clk);
    watch();
    chk(seen, 32'h0000_0000);
    apb(1'b1, pwr_pkg::ADDR_DUTY, 32'h0000_0005);
    apb(1'b1, pwr_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    // fault with restart off, then with restart armed
    for (int arm = 0; arm < 2; arm++)
    begin
      apb(1'b1, pwr_pkg::ADDR_CTRL, arm ? 32'h0000_0003 : 32'h0000_0001);
      trip <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(irq, 32'h0000_0001);
      apb(1'b1, pwr_pkg::ADDR_STATUS, 32'h0000_0001);
      chk(shutdown_event_status, 32'h0000_0001);
      trip <= 1'b0;
      watch();
      chk(seen, arm);
      chk(shutdown_event_status, 1 - arm);
      if (arm == 0)
      begin
        apb(1'b1, pwr_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        chk(irq, 32'h0000_0000);
        apb(1'b1, pwr_pkg::ADDR_IRQ_EN, 32'h0000_0001);
        apb(1'b1, pwr_pkg::ADDR_STATUS, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        chk(shutdown_event_status, 32'h0000_0000);
        chk(irq, 32'h0000_0000);
      end
    end
    give_verdict();
  end
endmodule
